// ### hcl_bus_model.sv
module hcl_bus_model
   import hcl_pkg::*;
(
   input  wire logic            i_sys_clk,
   input  wire logic            i_stall,
   input  wire logic            i_bus_valid,
   input  wire hcl_bus_req_type i_bus_req,
   output      logic            o_bus_ready
);
   timeunit 1ns;
   timeprecision 1ps;
   hcl_bus_req_type got_q[$];
   initial o_bus_ready = 1'b0;
   // Ready alternates when not stalled, so slow answers are exercised as well.
   always @(negedge i_sys_clk)
      o_bus_ready <= !i_stall && !o_bus_ready;
   always @(posedge i_sys_clk)
      if (i_bus_valid && o_bus_ready)
         got_q.push_back(i_bus_req);
endmodule

// ### hcl_load_unit.sv
// Functional notes
// - Code-load page select takes no data words.
// - One NOP code; specials decoded above direct offsets.
// - Base pair at offsets 06/07, resets zero.
// - Base field bits 29:8; unused bits read zero.
// - One paged write moves up to 128 words.
// - CRC pair at offsets 04/05, resets zero.
// - Host write seeds CRC; read returns live value.
// - Each code-load write folds address and data.
// - Sixteen mailbox flags at offset 03, reset zero.
// - Flags show host or processor mailbox ownership.
// - System reset always enters boot mode.
// - Boot holds execution until code word 0 written.
// - Reset command without boot enable starts immediately.
// - Page select takes a numbered page or the code-load page.
// - Running code memory writes steal one cycle.
// - Command carries offset, length, direction; length+1 words.
// - Address increments after every data word.
// - Direction bit zero reads, one writes.

module hcl_word_fifo #(
   parameter int WIDTH = 16,
   parameter int DEPTH = 4
) (
   input  wire logic             i_sys_clk,
   input  wire logic             i_sys_rst,
   input  wire logic             i_in_valid,
   input  wire logic [WIDTH-1:0] i_in_data,
   output      logic             o_in_ready,
   output      logic             o_out_valid,
   output      logic [WIDTH-1:0] o_out_data,
   input  wire logic             i_out_ready
);
   localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
   localparam int CW = $clog2(DEPTH + 1);
   localparam logic [PW-1:0] LAST = PW'(DEPTH - 1);
   localparam logic [CW-1:0] FULL = CW'(DEPTH);

   logic [WIDTH-1:0] mem [DEPTH];
   logic [PW-1:0]    wr_ptr_reg;
   logic [PW-1:0]    rd_ptr_reg;
   logic [CW-1:0]    count_reg;
   logic             push;
   logic             pop;

   assign o_in_ready  = (count_reg != FULL);
   assign o_out_valid = (count_reg != '0);
   assign o_out_data  = mem[rd_ptr_reg];
   assign push        = i_in_valid & o_in_ready;
   assign pop         = o_out_valid & i_out_ready;

   always_ff @(posedge i_sys_clk)
   begin
      if (push)
         mem[wr_ptr_reg] <= i_in_data;
   end

   always_ff @(posedge i_sys_clk)
   begin
      if (i_sys_rst)
      begin
         wr_ptr_reg <= '0;
         rd_ptr_reg <= '0;
         count_reg  <= '0;
      end
      else
      begin
         if (push)
            wr_ptr_reg <= (wr_ptr_reg == LAST) ? '0 : wr_ptr_reg + 1'b1;
         if (pop)
            rd_ptr_reg <= (rd_ptr_reg == LAST) ? '0 : rd_ptr_reg + 1'b1;
         if (push & ~pop)
            count_reg <= count_reg + 1'b1;
         else if (pop & ~push)
            count_reg <= count_reg - 1'b1;
      end
   end
endmodule

module hcl_load_unit
   import hcl_pkg::*;
#(
   parameter int          FIFO_DEPTH     = 4,
   parameter logic [31:0] CM_BASE_ADDR   = 32'h0000_0000,
   parameter logic [31:0] CM_SIZE_BYTES  = 32'h0001_0000
) (
   input  wire logic            i_sys_clk,
   input  wire logic            i_sys_rst,
   input  wire logic            i_word_valid,
   input  wire logic [15:0]     i_word_data,
   output      logic            o_word_ready,
   input  wire logic            i_frame_abort,
   output      logic            o_rd_valid,
   output      logic [15:0]     o_rd_data,
   output      logic            o_bus_valid,
   output      hcl_bus_req_type o_bus_req,
   input  wire logic            i_bus_ready,
   input  wire logic            i_hw_reset_cmd,
   input  wire logic            i_boot_seq_enable,
   output      logic            o_exec_enable,
   output      logic            o_exec_start,
   output      logic            o_cm_steal,
   input  wire logic [15:0]     i_proc_flag_set,
   input  wire logic [15:0]     i_proc_flag_clr,
   output      logic [15:0]     o_mailbox_owner_bits
);
   hcl_state_type   state_reg;
   hcl_target_type  target_reg;
   logic [7:0]      remain_reg;
   logic [7:0]      index_reg;
   logic [3:0]      page_reg;
   logic            code_load_sel_reg;
   logic [31:0]     crc_reg;
   logic [15:0]     base_high_reg;
   logic [15:0]     base_low_reg;
   logic [15:0]     mailbox_reg;
   logic            boot_mode_reg;
   logic            exec_start_reg;
   logic            cm_steal_reg;
   logic            rd_valid_reg;
   logic [15:0]     rd_data_reg;

   logic            word_fire;
   logic            cmd_fire;
   logic            data_fire;
   logic            last_word;
   logic            host_reg_wr;
   logic [6:0]      direct_ofs;
   logic [21:0]     base_field;
   hcl_bus_req_type push_req;
   logic            fifo_in_valid;
   logic            fifo_in_ready;
   logic            bus_fire;
   logic            cl_push;
   logic [15:0]     direct_rd_value;
   logic [7:0]      cmd_upper;

   assign cmd_upper  = i_word_data[15:8];
   assign direct_ofs = index_reg[6:0];
   assign base_field = {base_high_reg[13:0], base_low_reg[15:8]};

   // Only paged writes wait on the bus; a full FIFO holds the host word stream.
   assign o_word_ready = (state_reg == ST_WRITE && target_reg == TGT_PAGED) ? fifo_in_ready : 1'b1;
   assign word_fire    = i_word_valid & o_word_ready;
   assign cmd_fire     = word_fire & (state_reg == ST_COMMAND);
   assign data_fire    = word_fire & (state_reg != ST_COMMAND);
   assign last_word    = (remain_reg == 8'h00);
   assign host_reg_wr  = data_fire & (state_reg == ST_WRITE) & (target_reg == TGT_DIRECT);

   always_comb
   begin
      push_req             = '0;
      push_req.data        = i_word_data;
      push_req.code_load   = code_load_sel_reg;
      if (code_load_sel_reg)
         push_req.addr     = hcl_cl_addr(base_field, index_reg);
      else
         push_req.addr     = {20'h00000, page_reg, index_reg};
      push_req.code_memory = code_load_sel_reg && (push_req.addr >= CM_BASE_ADDR)
                             && (push_req.addr < CM_BASE_ADDR + CM_SIZE_BYTES);
   end

   assign fifo_in_valid = i_word_valid & (state_reg == ST_WRITE) & (target_reg == TGT_PAGED);
   assign cl_push       = fifo_in_valid & fifo_in_ready & code_load_sel_reg;
   assign bus_fire      = o_bus_valid & i_bus_ready;

   hcl_word_fifo #(
      .WIDTH ($bits(hcl_bus_req_type)),
      .DEPTH (FIFO_DEPTH)
   ) u_write_fifo (
      .i_sys_clk   (i_sys_clk),
      .i_sys_rst   (i_sys_rst),
      .i_in_valid  (fifo_in_valid),
      .i_in_data   (push_req),
      .o_in_ready  (fifo_in_ready),
      .o_out_valid (o_bus_valid),
      .o_out_data  (o_bus_req),
      .i_out_ready (i_bus_ready)
   );

   // Transport command sequencing.
   always_ff @(posedge i_sys_clk)
   begin
      if (i_sys_rst || i_frame_abort)
      begin
         state_reg  <= ST_COMMAND;
         target_reg <= TGT_PAGED;
         remain_reg <= 8'h00;
         index_reg  <= 8'h00;
      end
      else if (cmd_fire)
      begin
         if (!i_word_data[CMD_DIRECT_BIT])
         begin
            target_reg <= TGT_PAGED;
            index_reg  <= {1'b0, i_word_data[14:8]};
            remain_reg <= {1'b0, i_word_data[6:0]};
            state_reg  <= i_word_data[CMD_RW_BIT] ? ST_WRITE : ST_READ;
         end
         else if (i_word_data[14:8] < OFS_DIRECT_RSVD)
         begin
            target_reg <= TGT_DIRECT;
            index_reg  <= {1'b0, i_word_data[14:8]};
            remain_reg <= {4'h0, i_word_data[3:0]};
            state_reg  <= i_word_data[CMD_RW_BIT] ? ST_WRITE : ST_READ;
         end
         else if (cmd_upper[7:1] == CMD_MBOX_START || cmd_upper[7:1] == CMD_MBOX_CONT)
         begin
            target_reg <= TGT_MBOX;
            index_reg  <= 8'h00;
            remain_reg <= i_word_data[7:0];
            state_reg  <= cmd_upper[0] ? ST_WRITE : ST_READ;
         end
      end
      else if (data_fire)
      begin
         index_reg  <= index_reg + 8'h01;
         remain_reg <= remain_reg - 8'h01;
         if (last_word)
            state_reg <= ST_COMMAND;
      end
   end

   // Page selection; configure, NOP and reserved codes take no data and change nothing here.
   always_ff @(posedge i_sys_clk)
   begin
      if (i_sys_rst)
      begin
         page_reg          <= PAGE_RST;
         code_load_sel_reg <= 1'b0;
      end
      else if (cmd_fire && cmd_upper == CMD_SELECT_PAGE)
      begin
         if (i_word_data[7:0] == SEL_CODE_LOAD_PAGE)
            code_load_sel_reg <= 1'b1;
         else if (i_word_data[7:4] == SEL_PAGE_PREFIX)
         begin
            page_reg          <= i_word_data[3:0];
            code_load_sel_reg <= 1'b0;
         end
      end
   end

   // CRC seeding by halves and folding of each code-load write.
   always_ff @(posedge i_sys_clk)
   begin
      if (i_sys_rst)
         crc_reg <= CRC_RST;
      else if (cl_push)
         crc_reg <= hcl_crc_fold(crc_reg, {push_req.addr, push_req.data});
      else if (host_reg_wr && direct_ofs == OFS_CRC_HIGH)
         crc_reg[31:16] <= i_word_data;
      else if (host_reg_wr && direct_ofs == OFS_CRC_LOW)
         crc_reg[15:0] <= i_word_data;
   end

   // Base address halves.
   always_ff @(posedge i_sys_clk)
   begin
      if (i_sys_rst)
      begin
         base_high_reg <= BASE_HALF_RST;
         base_low_reg  <= BASE_HALF_RST;
      end
      else if (host_reg_wr && direct_ofs == OFS_BASE_HIGH)
         base_high_reg <= i_word_data & BASE_HIGH_MASK;
      else if (host_reg_wr && direct_ofs == OFS_BASE_LOW)
         base_low_reg <= i_word_data & BASE_LOW_MASK;
   end

   // Processor set wins over a host write or a clear in the same cycle.
   always_ff @(posedge i_sys_clk)
   begin
      if (i_sys_rst)
         mailbox_reg <= MAILBOX_RST;
      else if (host_reg_wr && direct_ofs == OFS_MAILBOX_FLAGS)
         mailbox_reg <= i_word_data | i_proc_flag_set;
      else
         mailbox_reg <= (mailbox_reg & ~i_proc_flag_clr) | i_proc_flag_set;
   end

   assign o_mailbox_owner_bits = mailbox_reg;

   // Apart from a reset command without boot enable, boot hold-off releases only once the write to code word 0 has reached the bus.
   always_ff @(posedge i_sys_clk)
   begin
      if (i_sys_rst)
      begin
         boot_mode_reg  <= 1'b1;
         exec_start_reg <= 1'b0;
      end
      else if (i_hw_reset_cmd)
      begin
         boot_mode_reg  <= i_boot_seq_enable;
         exec_start_reg <= ~i_boot_seq_enable;
      end
      else if (boot_mode_reg && bus_fire && o_bus_req.code_load && o_bus_req.addr == CM_BASE_ADDR)
      begin
         boot_mode_reg  <= 1'b0;
         exec_start_reg <= 1'b1;
      end
      else
         exec_start_reg <= 1'b0;
   end

   assign o_exec_enable = ~boot_mode_reg;
   assign o_exec_start  = exec_start_reg;

   // A running processor loses one cycle per code memory write instead of blocking the host.
   always_ff @(posedge i_sys_clk)
   begin
      if (i_sys_rst)
         cm_steal_reg <= 1'b0;
      else
         cm_steal_reg <= bus_fire & o_bus_req.code_memory & ~boot_mode_reg;
   end

   assign o_cm_steal = cm_steal_reg;

   always_comb
   begin
      direct_rd_value = 16'h0000;
      unique case (direct_ofs)
         OFS_MAILBOX_FLAGS : direct_rd_value = mailbox_reg;
         OFS_CRC_HIGH      : direct_rd_value = crc_reg[31:16];
         OFS_CRC_LOW       : direct_rd_value = crc_reg[15:0];
         OFS_BASE_HIGH     : direct_rd_value = base_high_reg;
         OFS_BASE_LOW      : direct_rd_value = base_low_reg;
         default           : direct_rd_value = 16'h0000;
      endcase
   end

   // Firmware-held locations are not modelled here, so they read as zero.
   always_ff @(posedge i_sys_clk)
   begin
      if (i_sys_rst)
      begin
         rd_valid_reg <= 1'b0;
         rd_data_reg  <= 16'h0000;
      end
      else
      begin
         rd_valid_reg <= data_fire & (state_reg == ST_READ);
         if (data_fire && state_reg == ST_READ)
            rd_data_reg <= (target_reg == TGT_DIRECT) ? direct_rd_value : 16'h0000;
      end
   end

   assign o_rd_valid = rd_valid_reg;
   assign o_rd_data  = rd_data_reg;

endmodule

// ### hcl_load_unit_bench.sv
module hcl_load_unit_bench
   import hcl_pkg::*;
   ;
   timeunit 1ns;
   timeprecision 1ps;
   logic            clk = 1'b0, rst = 1'b1, wv = 1'b0, abort = 1'b0;
   logic            hwr = 1'b0, bse = 1'b0, stall = 1'b0;
   logic [15:0]     wd = 16'h0000, fset = 16'h0000, fclr = 16'h0000;
   logic            word_ready, rd_valid, bus_valid, bus_ready, exec_en, exec_start, steal;
   logic [15:0]     rd_data, mbox;
   hcl_bus_req_type bus_req;
   hcl_bus_req_type exp_q[$];
   logic [31:0]     crc;
   int              n_fail = 0, checks = 0, n_steal = 0, n_start = 0;
   always #2.5 clk = !clk;
   always @(posedge clk)
      if (steal === 1'b1)
         n_steal++;
   // The start strobe lasts one cycle, so it is counted rather than looked at once.
   always @(posedge clk)
      if (exec_start === 1'b1)
         n_start++;
   hcl_load_unit u_hcl_load_unit (.i_sys_clk(clk), .i_sys_rst(rst), .i_word_valid(wv), .i_word_data(wd),
      .o_word_ready(word_ready), .i_frame_abort(abort), .o_rd_valid(rd_valid), .o_rd_data(rd_data),
      .o_bus_valid(bus_valid), .o_bus_req(bus_req), .i_bus_ready(bus_ready), .i_hw_reset_cmd(hwr),
      .i_boot_seq_enable(bse), .o_exec_enable(exec_en), .o_exec_start(exec_start), .o_cm_steal(steal),
      .i_proc_flag_set(fset), .i_proc_flag_clr(fclr), .o_mailbox_owner_bits(mbox));
   hcl_bus_model u_hcl_bus_model (.i_sys_clk(clk), .i_stall(stall), .i_bus_valid(bus_valid),
      .i_bus_req(bus_req), .o_bus_ready(bus_ready));
   task automatic stop_test();
      $display("checks=%0d n_fail=%0d", checks, n_fail);
      if (n_fail == 0 && checks > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask
   task automatic chk(input logic [63:0] got, input logic [63:0] exp);
      checks++;
      if (got !== exp)
      begin
         n_fail++;
         $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   // The word is held until taken; valid stays up so bursts go back to back.
   task automatic put(input logic [15:0] w);
      int n;
      n = 0;
      @(negedge clk);
      wv = 1'b1;
      wd = w;
      while (word_ready !== 1'b1 && n < 300)
      begin
         @(negedge clk);
         n++;
      end
      @(posedge clk);
   endtask
   task automatic idle();
      @(negedge clk);
      wv = 1'b0;
   endtask
   task automatic rdchk(input logic [6:0] ofs, input logic [15:0] exp);
      int n;
      n = 0;
      put({1'b1, ofs, 8'h00});
      put(16'h0000);
      idle();
      while (rd_valid !== 1'b1 && n < 3)
      begin
         @(negedge clk);
         n++;
      end
      chk(64'(rd_valid), 64'h1);
      chk(64'(rd_data), 64'(exp));
   endtask
   task automatic wr(input logic [6:0] ofs, input logic [15:0] d);
      put({1'b1, ofs, 8'h80});
      put(d);
      idle();
   endtask
   function automatic logic [31:0] fold(input logic [31:0] c, input logic [47:0] b);
      for (int i = 47; i >= 0; i--)
         c = {c[30:0], 1'b0} ^ ((c[31] ^ b[i]) ? CRC_POLY : 32'h0000_0000);
      return c;
   endfunction
   task automatic clw(input logic [6:0] ofs, input logic [6:0] len, input logic [29:0] base);
      logic [31:0] a;
      put({1'b0, ofs, 1'b1, len});
      for (int i = 0; i <= int'(len); i++)
      begin
         a = {2'b00, base + 30'((int'(ofs) + i) * 2)};
         exp_q.push_back({1'b1, a < 32'h0001_0000, a, a[15:0] ^ 16'ha5a5});
         crc = fold(crc, {a, a[15:0] ^ 16'ha5a5});
         put(a[15:0] ^ 16'ha5a5);
      end
      idle();
   endtask
   task automatic drain();
      int n;
      n = 0;
      while (u_hcl_bus_model.got_q.size() < exp_q.size() && n < 500)
      begin
         @(negedge clk);
         n++;
      end
      chk(64'(u_hcl_bus_model.got_q.size()), 64'(exp_q.size()));
      while (exp_q.size() > 0 && u_hcl_bus_model.got_q.size() > 0)
         chk(64'(u_hcl_bus_model.got_q.pop_front()), 64'(exp_q.pop_front()));
   endtask
   initial
   begin
      #100us;
      n_fail++;
      stop_test();
   end
   initial
   begin
      repeat (8) @(negedge clk);
      rst = 1'b0;
      for (int r = 3; r <= 7; r++)
         rdchk(7'(r), 16'h0000);
      chk(64'(exec_en), 64'h0);
      wr(OFS_BASE_HIGH, 16'hffff);
      wr(OFS_BASE_LOW, 16'hffff);
      rdchk(OFS_BASE_HIGH, 16'h3fff);
      rdchk(OFS_BASE_LOW, 16'hff00);
      wr(OFS_BASE_HIGH, 16'h0012);
      wr(OFS_BASE_LOW, 16'h3400);
      wr(OFS_CRC_HIGH, 16'hdead);
      wr(OFS_CRC_LOW, 16'hbeef);
      crc = 32'hdead_beef;
      put(16'hffff);
      put(16'hfd00);
      idle();
      rdchk(OFS_CRC_HIGH, 16'hdead);
      rdchk(OFS_CRC_LOW, 16'hbeef);
      put(16'hfe80);
      stall = 1'b1;
      fork
         clw(7'h7a, 7'h05, 30'h0012_3400);
         begin
            repeat (30) @(negedge clk);
            chk(64'(word_ready), 64'h0);
            stall = 1'b0;
         end
      join
      drain();
      rdchk(OFS_CRC_HIGH, crc[31:16]);
      rdchk(OFS_CRC_LOW, crc[15:0]);
      chk(64'(exec_en), 64'h0);
      put({1'b1, OFS_MAILBOX_FLAGS, 8'h80});
      idle();
      abort = 1'b1;
      @(negedge clk);
      abort = 1'b0;
      rdchk(OFS_MAILBOX_FLAGS, 16'h0000);
      wr(OFS_BASE_HIGH, 16'h0000);
      wr(OFS_BASE_LOW, 16'h0000);
      clw(7'h00, 7'h00, 30'h0);
      drain();
      repeat (2) @(negedge clk);
      chk(64'(exec_en), 64'h1);
      chk(64'(n_start), 64'h1);
      clw(7'h01, 7'h00, 30'h0);
      drain();
      repeat (2) @(negedge clk);
      chk(64'(n_steal), 64'h1);
      hwr = 1'b1;
      bse = 1'b1;
      @(negedge clk);
      hwr = 1'b0;
      chk(64'(exec_en), 64'h0);
      hwr = 1'b1;
      bse = 1'b0;
      @(negedge clk);
      hwr = 1'b0;
      chk(64'(exec_en), 64'h1);
      chk(64'(exec_start), 64'h1);
      wr(OFS_MAILBOX_FLAGS, 16'h00f0);
      fset = 16'h0003;
      @(negedge clk);
      fset = 16'h0000;
      fclr = 16'h0010;
      @(negedge clk);
      fclr = 16'h0000;
      rdchk(OFS_MAILBOX_FLAGS, 16'h00e3);
      chk(64'(mbox), 64'h00e3);
      // A two-word direct write, then a mailbox write whose words must all be swallowed.
      put({1'b1, OFS_BASE_HIGH, 8'h81});
      put(16'h0001);
      put(16'h0200);
      put(16'hf901);
      put(16'h1111);
      put(16'h2222);
      idle();
      rdchk(OFS_BASE_HIGH, 16'h0001);
      rdchk(OFS_BASE_LOW, 16'h0200);
      // An ordinary page leaves the code-load path, so the CRC must not move.
      put(16'hfe03);
      exp_q.push_back({1'b0, 1'b0, 32'h0000_0310, 16'h1234});
      put(16'h1080);
      put(16'h1234);
      idle();
      drain();
      rdchk(OFS_CRC_HIGH, crc[31:16]);
      rdchk(OFS_CRC_LOW, crc[15:0]);
      chk(64'(n_start), 64'h2);
      stop_test();
   end
endmodule
bind hcl_load_unit hcl_load_unit_sva #(.CM_BASE_ADDR(CM_BASE_ADDR)) u_hcl_load_unit_sva (.i_sys_clk(i_sys_clk),
   .i_sys_rst(i_sys_rst), .o_word_ready(o_word_ready), .o_bus_valid(o_bus_valid), .o_bus_req(o_bus_req),
   .i_bus_ready(i_bus_ready), .i_hw_reset_cmd(i_hw_reset_cmd), .i_boot_seq_enable(i_boot_seq_enable),
   .o_exec_enable(o_exec_enable), .o_exec_start(o_exec_start), .o_cm_steal(o_cm_steal),
   .i_proc_flag_set(i_proc_flag_set), .o_mailbox_owner_bits(o_mailbox_owner_bits));

// ### hcl_load_unit_sva.sv
module hcl_load_unit_sva
   import hcl_pkg::*;
#(
   parameter logic [31:0] CM_BASE_ADDR = 32'h0000_0000
) (
   input wire logic            i_sys_clk,
   input wire logic            i_sys_rst,
   input wire logic            o_word_ready,
   input wire logic            o_bus_valid,
   input wire hcl_bus_req_type o_bus_req,
   input wire logic            i_bus_ready,
   input wire logic            i_hw_reset_cmd,
   input wire logic            i_boot_seq_enable,
   input wire logic            o_exec_enable,
   input wire logic            o_exec_start,
   input wire logic            o_cm_steal,
   input wire logic [15:0]     i_proc_flag_set,
   input wire logic [15:0]     o_mailbox_owner_bits
);
   default clocking @(posedge i_sys_clk); endclocking
   default disable iff (i_sys_rst);
   logic fire;
   assign fire = o_bus_valid && i_bus_ready;
   sequence s_start;
      o_exec_enable && o_exec_start ##1 !o_exec_start;
   endsequence
   sequence s_boot_fire;
      !o_exec_enable && fire && o_bus_req.code_load && o_bus_req.addr == CM_BASE_ADDR && !i_hw_reset_cmd;
   endsequence
   property p_release;
      s_boot_fire |=> s_start;
   endproperty
   a_release: assert property (p_release) else $error("boot release missing");
   property p_hold;
      !o_exec_enable && !fire && !i_hw_reset_cmd |=> !o_exec_enable;
   endproperty
   a_hold: assert property (p_hold) else $error("execution left boot hold");
   property p_noboot;
      i_hw_reset_cmd && !i_boot_seq_enable |=> s_start;
   endproperty
   a_noboot: assert property (p_noboot) else $error("no immediate start");
   property p_boot;
      i_hw_reset_cmd && i_boot_seq_enable |=> !o_exec_enable && !o_exec_start;
   endproperty
   a_boot: assert property (p_boot) else $error("boot mode not entered");
   property p_steal;
      fire && o_bus_req.code_memory && o_exec_enable |=> o_cm_steal;
   endproperty
   a_steal: assert property (p_steal) else $error("steal pulse missing");
   property p_no_steal;
      !(fire && o_bus_req.code_memory) |=> !o_cm_steal;
   endproperty
   a_no_steal: assert property (p_no_steal) else $error("spurious steal");
   property p_hold_req;
      o_bus_valid && !i_bus_ready |=> o_bus_valid && $stable(o_bus_req);
   endproperty
   a_hold_req: assert property (p_hold_req) else $error("bus request dropped");
   property p_full;
      !o_word_ready |-> o_bus_valid;
   endproperty
   a_full: assert property (p_full) else $error("stall with empty queue");
   property p_cl_addr;
      o_bus_valid && o_bus_req.code_load |-> o_bus_req.addr[31:30] == 2'b00 && !o_bus_req.addr[0];
   endproperty
   a_cl_addr: assert property (p_cl_addr) else $error("bad load address");
   property p_mbox;
      i_proc_flag_set != 16'h0000 |=> (o_mailbox_owner_bits & $past(i_proc_flag_set)) == $past(i_proc_flag_set);
   endproperty
   a_mbox: assert property (p_mbox) else $error("flag set lost");
endmodule

// ### hcl_pkg.sv
package hcl_pkg;

   // Direct page offsets of the hardware registers.
   localparam logic [6:0]  OFS_MAILBOX_FLAGS  = 7'h03;
   localparam logic [6:0]  OFS_CRC_HIGH       = 7'h04;
   localparam logic [6:0]  OFS_CRC_LOW        = 7'h05;
   localparam logic [6:0]  OFS_BASE_HIGH      = 7'h06;
   localparam logic [6:0]  OFS_BASE_LOW       = 7'h07;
   localparam logic [6:0]  OFS_DIRECT_RSVD    = 7'h78;

   // Values after reset.
   localparam logic [15:0] MAILBOX_RST        = 16'h0000;
   localparam logic [31:0] CRC_RST            = 32'h0000_0000;
   localparam logic [15:0] BASE_HALF_RST      = 16'h0000;
   localparam logic [3:0]  PAGE_RST           = 4'h0;

   // Field layout of the base register pair.
   localparam logic [15:0] BASE_HIGH_MASK     = 16'h3fff;
   localparam logic [15:0] BASE_LOW_MASK      = 16'hff00;

   // Command word field positions and encodings.
   localparam int          CMD_DIRECT_BIT     = 15;
   localparam int          CMD_RW_BIT         = 7;
   localparam logic [6:0]  CMD_MBOX_START     = 7'h7c;
   localparam logic [6:0]  CMD_MBOX_CONT      = 7'h7d;
   localparam logic [7:0]  CMD_CONFIGURE      = 8'hfd;
   localparam logic [7:0]  CMD_SELECT_PAGE    = 8'hfe;
   localparam logic [7:0]  CMD_NOP            = 8'hff;
   localparam logic [7:0]  SEL_CODE_LOAD_PAGE = 8'h80;
   localparam logic [3:0]  SEL_PAGE_PREFIX    = 4'h0;

   // CRC-32, MSB first, 32 address bits then 16 data bits per write.
   localparam logic [31:0] CRC_POLY           = 32'h04c1_1db7;
   localparam int          CRC_FOLD_BITS      = 48;

   typedef enum logic [2:0] {
      ST_COMMAND = 3'b001,
      ST_WRITE   = 3'b010,
      ST_READ    = 3'b100
   } hcl_state_type;

   typedef enum logic [1:0] {
      TGT_PAGED  = 2'b00,
      TGT_DIRECT = 2'b01,
      TGT_MBOX   = 2'b10
   } hcl_target_type;

   typedef struct packed {
      logic        code_load;
      logic        code_memory;
      logic [31:0] addr;
      logic [15:0] data;
   } hcl_bus_req_type;

   function automatic logic [31:0] hcl_crc_fold(input logic [31:0] crc,
                                                input logic [47:0] bits);
      logic [31:0] c;
      c = crc;
      for (int i = CRC_FOLD_BITS - 1; i >= 0; i--)
      begin
         if (c[31] ^ bits[i])
            c = {c[30:0], 1'b0} ^ CRC_POLY;
         else
            c = {c[30:0], 1'b0};
      end
      return c;
   endfunction

   function automatic logic [31:0] hcl_cl_addr(input logic [21:0] base,
                                               input logic [7:0]  index);
      logic [29:0] sum;
      sum = {base, 8'h00} + {21'h00000, index, 1'b0};
      return {2'b00, sum};
   endfunction

endpackage
